/* File: rtl/pin_route_pkg.sv */
package pin_route_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [4:0] OFS_UPPER_ADDR_DATA_SELECT = 5'h10;
  localparam logic [4:0] OFS_ADDRESS_DATA_SELECT_A  = 5'h14;
  localparam logic [4:0] OFS_ADDRESS_DATA_SELECT_B  = 5'h18;
  localparam logic [4:0] OFS_WIDTH_AND_POWER_CTRL   = 5'h1c;
  localparam logic [4:0] OFS_HOLD_SELECT            = 5'h04;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int         POS_LOCAL_POWER_DOWN = 0;
  localparam int         POS_WIDTH_LO         = 1;
  localparam int         POS_HOLD_SELECT      = 7;
  localparam logic [7:0] CTRL_WRITE_MASK      = 8'h07;
  localparam logic [7:0] RST_SELECT           = 8'h00;
  localparam logic [7:0] RST_CTRL             = 8'h00;

  typedef enum logic [1:0] {
    width_8  = 2'h0,
    width_16 = 2'h1,
    width_r2 = 2'h2,
    width_r3 = 2'h3
  } bus_width_t;

endpackage

/* File: rtl/pin_route_if.sv */
`timescale 1ns/1ps
interface pin_route_if;
  logic [7:0] select;
  logic       wide;
  logic [7:0] narrow_src;
  logic [7:0] wide_src;
  logic [7:0] gpio_src;
  logic [7:0] pin;

  modport ctrl (output select, output wide, output narrow_src, output wide_src, output gpio_src, input pin);
  modport mux  (input select, input wide, input narrow_src, input wide_src, input gpio_src, output pin);
endinterface

/* File: rtl/pin_byte_mux.sv */
`timescale 1ns/1ps
module pin_byte_mux
(
  pin_route_if.mux m
);
  // ****************************************************************
  // Per-bit routing
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_bit
      assign m.pin[g] = m.select[g] ? (m.wide ? m.wide_src[g] : m.narrow_src[g]) : m.gpio_src[g];  // R1 R2 R3 R4 R12
    end
  endgenerate
endmodule

/* File: rtl/expansion_bus_pin_mux.sv */
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// R1 - Select set: addr 13-6 or data 15-8.
// R2 - Second select: addr 21-14 or 13-6.
// R3 - Third select: addr 29-22 or 21-14.
// R4 - Cleared select bit routes general-purpose I/O.
// R5 - Control bits 7-6 read zero, ignore writes.
// R6 - Control bits 5-3 held at zero.
// R7 - Width field: 00 8-bit, 01 16-bit.
// R8 - Control bit 0 sets local power-down.
// R9 - Host configures clocks, reset, then selects.
// R10 - Slow peripherals assert hold during reads.
// R11 - Hold select makes pin a wait input.
// R12 - Routing follows select bits combinationally.
module expansion_bus_pin_mux
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  input  wire logic [29:0] bus_address_line_i,
  input  wire logic [15:0] bus_data_line_i,
  input  wire logic [23:0] gpio_out_i,
  output logic      [23:0] pin_out_o,
  input  wire logic        hold_pin_i,
  output logic             wait_request_o,
  output logic             local_power_down_o,
  output logic             bus_wide_o
);
  import pin_route_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] upper_addr_data_select;
  logic [7:0] address_data_select_a;
  logic [7:0] address_data_select_b;
  logic [7:0] width_and_power_control;
  logic       hold_select;
  logic       hold_s1;
  logic       hold_s2;
  logic       req;
  logic       hit;
  logic       wr_lane0;
  logic [7:0] rd_byte;
  logic       wide;

  assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign wr_lane0 = req && wb_we_i && wb_sel_i[0];

  always_comb
  begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    case (wb_adr_i)
      OFS_UPPER_ADDR_DATA_SELECT: rd_byte = upper_addr_data_select;
      OFS_ADDRESS_DATA_SELECT_A:  rd_byte = address_data_select_a;
      OFS_ADDRESS_DATA_SELECT_B:  rd_byte = address_data_select_b;
      OFS_WIDTH_AND_POWER_CTRL:   rd_byte = width_and_power_control & CTRL_WRITE_MASK;  // R5 R6
      OFS_HOLD_SELECT:            rd_byte = {hold_select, 7'h00};
      default:                    hit = 1'b0;
    endcase
  end

  // Answer one cycle after the request; unmapped addresses get err.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req && hit;
      wb_err_o <= req && !hit;
      wb_dat_o <= (req && hit && !wb_we_i) ? {24'h000000, rd_byte} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      upper_addr_data_select  <= RST_SELECT;
      address_data_select_a   <= RST_SELECT;
      address_data_select_b   <= RST_SELECT;
      width_and_power_control <= RST_CTRL;
      hold_select             <= 1'b0;
    end
    else if (wr_lane0)
    begin
      case (wb_adr_i)
        OFS_UPPER_ADDR_DATA_SELECT: upper_addr_data_select <= wb_dat_i[7:0];
        OFS_ADDRESS_DATA_SELECT_A:  address_data_select_a  <= wb_dat_i[7:0];
        OFS_ADDRESS_DATA_SELECT_B:  address_data_select_b  <= wb_dat_i[7:0];
        OFS_WIDTH_AND_POWER_CTRL:   width_and_power_control <= wb_dat_i[7:0] & CTRL_WRITE_MASK;  // R5 R6
        OFS_HOLD_SELECT:            hold_select <= wb_dat_i[POS_HOLD_SELECT];
        default:                    hold_select <= hold_select;
      endcase
    end
  end

  // ****************************************************************
  // Width and power
  // ****************************************************************
  // Reserved width codes behave as 8-bit so the pins never float to an undefined source.
  assign wide               = bus_width_t'(width_and_power_control[POS_WIDTH_LO +: 2]) == width_16;  // R7
  assign bus_wide_o         = wide;
  assign local_power_down_o = width_and_power_control[POS_LOCAL_POWER_DOWN];  // R8

  // ****************************************************************
  // Hold input
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hold_s1 <= 1'b0;
      hold_s2 <= 1'b0;
    end
    else
    begin
      hold_s1 <= hold_pin_i;
      hold_s2 <= hold_s1;
    end
  end

  assign wait_request_o = hold_select && hold_s2;  // R11 R10

  // ****************************************************************
  // Pin routing
  // ****************************************************************
  pin_route_if r0 ();
  pin_route_if r1 ();
  pin_route_if r2 ();

  assign r0.select     = upper_addr_data_select;
  assign r0.wide       = wide;
  assign r0.narrow_src = bus_address_line_i[13:6];  // R1
  assign r0.wide_src   = bus_data_line_i[15:8];  // R1
  assign r0.gpio_src   = gpio_out_i[7:0];
  assign r1.select     = address_data_select_a;
  assign r1.wide       = wide;
  assign r1.narrow_src = bus_address_line_i[21:14];  // R2
  assign r1.wide_src   = bus_address_line_i[13:6];  // R2
  assign r1.gpio_src   = gpio_out_i[15:8];
  assign r2.select     = address_data_select_b;
  assign r2.wide       = wide;
  assign r2.narrow_src = bus_address_line_i[29:22];  // R3
  assign r2.wide_src   = bus_address_line_i[21:14];  // R3
  assign r2.gpio_src   = gpio_out_i[23:16];

  pin_byte_mux u_mux0 (.m(r0.mux));
  pin_byte_mux u_mux1 (.m(r1.mux));
  pin_byte_mux u_mux2 (.m(r2.mux));

  assign pin_out_o = {r2.pin, r1.pin, r0.pin};

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_R1_WIDE: assert property (@(posedge clk_i) disable iff (rst_i)  // R1
    (upper_addr_data_select[0] && wide) |-> pin_out_o[0] == bus_data_line_i[8])
    else $error("Wide select bit 0 not routing data 8.");
  AST_R1_NARROW: assert property (@(posedge clk_i) disable iff (rst_i)  // R1
    (upper_addr_data_select[7] && !wide) |-> pin_out_o[7] == bus_address_line_i[13])
    else $error("Narrow select bit 7 not routing address 13.");
  AST_R2: assert property (@(posedge clk_i) disable iff (rst_i)  // R2
    address_data_select_a[3] |-> pin_out_o[11] == (wide ? bus_address_line_i[9] : bus_address_line_i[17]))
    else $error("Second select routing wrong.");
  AST_R3: assert property (@(posedge clk_i) disable iff (rst_i)  // R3
    address_data_select_b[7] |-> pin_out_o[23] == (wide ? bus_address_line_i[21] : bus_address_line_i[29]))
    else $error("Third select routing wrong.");
  AST_R4: assert property (@(posedge clk_i) disable iff (rst_i)  // R4
    !address_data_select_a[0] |-> pin_out_o[8] == gpio_out_i[8])
    else $error("Cleared select not routing general-purpose I/O.");
  AST_R5: assert property (@(posedge clk_i) disable iff (rst_i)  // R5
    (wb_ack_o && $past(wb_adr_i) == OFS_WIDTH_AND_POWER_CTRL) |-> wb_dat_o[7:6] == 2'h0)
    else $error("Control bits 7-6 not zero.");
  AST_R6: assert property (@(posedge clk_i) disable iff (rst_i)  // R6
    width_and_power_control[5:3] == 3'h0)
    else $error("Control bits 5-3 not zero.");
  AST_R7: assert property (@(posedge clk_i) disable iff (rst_i)  // R7
    (wr_lane0 && wb_adr_i == OFS_WIDTH_AND_POWER_CTRL && wb_dat_i[2:1] == 2'h1) |=> bus_wide_o)
    else $error("Width 01 did not select 16-bit.");
  AST_R8: assert property (@(posedge clk_i) disable iff (rst_i)  // R8
    (wr_lane0 && wb_adr_i == OFS_WIDTH_AND_POWER_CTRL) |=> local_power_down_o == $past(wb_dat_i[0]))
    else $error("Power-down bit not following write.");
  AST_R11: assert property (@(posedge clk_i) disable iff (rst_i)  // R11
    (hold_select && $past(hold_pin_i, 2) && $past(hold_select)) |-> wait_request_o)
    else $error("Hold pin not raising wait request.");
  AST_R12: assert property (@(posedge clk_i) disable iff (rst_i)  // R12
    (wr_lane0 && wb_adr_i == OFS_ADDRESS_DATA_SELECT_B) |=> pin_out_o[16] ==
      ($past(wb_dat_i[0]) ? (wide ? bus_address_line_i[14] : bus_address_line_i[22]) : gpio_out_i[16]))
    else $error("Routing did not follow select write.");

  // ****************************************************************
  // Routing checks, every pin
  // ****************************************************************
  // Each pin is held against the bus line that its rule names, not against the mux expression.
  generate
    for (genvar b = 0; b < 8; b++)
    begin : g_route_check
      AST_R1_BIT: assert property (@(posedge clk_i) disable iff (rst_i)  // R1
        upper_addr_data_select[b] |->
          pin_out_o[b] == (wide ? bus_data_line_i[8 + b] : bus_address_line_i[6 + b]))
        else $error("Address/data select bit not routing its bus line.");
      AST_R2_BIT: assert property (@(posedge clk_i) disable iff (rst_i)  // R2
        address_data_select_a[b] |->
          pin_out_o[8 + b] == (wide ? bus_address_line_i[6 + b] : bus_address_line_i[14 + b]))
        else $error("Second select bit not routing its address line.");
      AST_R3_BIT: assert property (@(posedge clk_i) disable iff (rst_i)  // R3
        address_data_select_b[b] |->
          pin_out_o[16 + b] == (wide ? bus_address_line_i[14 + b] : bus_address_line_i[22 + b]))
        else $error("Third select bit not routing its address line.");
      AST_R4_BIT_UPPER: assert property (@(posedge clk_i) disable iff (rst_i)  // R4
        !upper_addr_data_select[b] |-> pin_out_o[b] == gpio_out_i[b])
        else $error("Cleared address/data select bit not routing general-purpose I/O.");
      AST_R4_BIT_A: assert property (@(posedge clk_i) disable iff (rst_i)  // R4
        !address_data_select_a[b] |-> pin_out_o[8 + b] == gpio_out_i[8 + b])
        else $error("Cleared second select bit not routing general-purpose I/O.");
      AST_R4_BIT_B: assert property (@(posedge clk_i) disable iff (rst_i)  // R4
        !address_data_select_b[b] |-> pin_out_o[16 + b] == gpio_out_i[16 + b])
        else $error("Cleared third select bit not routing general-purpose I/O.");
    end
  endgenerate

  // ****************************************************************
  // Bus and register checks
  // ****************************************************************
  // A refused write must leave every register alone, or a stray strobe would reroute live pins.
  AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)  // R12
    wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge held longer than one cycle.");
  AST_ERR_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)  // R12
    wb_err_o |=> !wb_err_o)
    else $error("Error held longer than one cycle.");
  AST_ONE_ANSWER: assert property (@(posedge clk_i) disable iff (rst_i)  // R12
    !(wb_ack_o && wb_err_o))
    else $error("Acknowledge and error given together.");
  AST_ANSWER_NEXT: assert property (@(posedge clk_i) disable iff (rst_i)  // R12
    req |=> (wb_ack_o || wb_err_o))
    else $error("Request not answered in the next cycle.");
  AST_ANSWER_ASKED: assert property (@(posedge clk_i) disable iff (rst_i)  // R12
    (wb_ack_o || wb_err_o) |-> ($past(wb_cyc_i) && $past(wb_stb_i)))
    else $error("Answer given without a request.");
  AST_RD_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)  // R5
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("Read data not zero outside an answer.");
  AST_R5_UPPER_LANES: assert property (@(posedge clk_i) disable iff (rst_i)  // R5
    wb_dat_o[31:8] == 24'h000000)
    else $error("Upper read lanes not zero.");
  AST_R5_STORE: assert property (@(posedge clk_i) disable iff (rst_i)  // R5
    width_and_power_control[7:6] == 2'h0)
    else $error("Reserved control bits stored a written value.");
  AST_R6_READ: assert property (@(posedge clk_i) disable iff (rst_i)  // R6
    (wb_ack_o && $past(wb_adr_i) == OFS_WIDTH_AND_POWER_CTRL) |-> wb_dat_o[5:3] == 3'h0)
    else $error("Control bits 5-3 not read as zero.");
  AST_R7_NARROW: assert property (@(posedge clk_i) disable iff (rst_i)  // R7
    (width_and_power_control[POS_WIDTH_LO +: 2] != 2'h1) |-> !bus_wide_o)
    else $error("Width code other than 01 selected 16-bit.");
  AST_R7_WIDE: assert property (@(posedge clk_i) disable iff (rst_i)  // R7
    (width_and_power_control[POS_WIDTH_LO +: 2] == 2'h1) |-> bus_wide_o)
    else $error("Width code 01 did not select 16-bit.");
  AST_R8_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)  // R8
    !(wr_lane0 && wb_adr_i == OFS_WIDTH_AND_POWER_CTRL) |=> $stable(local_power_down_o))
    else $error("Power-down changed without a control write.");
  AST_SEL_LANE: assert property (@(posedge clk_i) disable iff (rst_i)  // R12
    (req && wb_we_i && !wb_sel_i[0]) |=> ($stable(upper_addr_data_select) && $stable(address_data_select_a) &&
      $stable(address_data_select_b) && $stable(width_and_power_control) && $stable(hold_select)))
    else $error("Write without lane 0 changed a register.");
  AST_UNMAPPED: assert property (@(posedge clk_i) disable iff (rst_i)  // R12
    (req && !hit) |=> ($stable(upper_addr_data_select) && $stable(address_data_select_a) &&
      $stable(address_data_select_b) && $stable(width_and_power_control) && $stable(hold_select)))
    else $error("Unmapped access changed a register.");
  AST_R12_UPPER: assert property (@(posedge clk_i) disable iff (rst_i)  // R12
    (wr_lane0 && wb_adr_i == OFS_UPPER_ADDR_DATA_SELECT) |=> upper_addr_data_select == $past(wb_dat_i[7:0]))
    else $error("Address/data select write not stored.");
  AST_R12_A: assert property (@(posedge clk_i) disable iff (rst_i)  // R12
    (wr_lane0 && wb_adr_i == OFS_ADDRESS_DATA_SELECT_A) |=> address_data_select_a == $past(wb_dat_i[7:0]))
    else $error("Second select write not stored.");
  AST_R12_B: assert property (@(posedge clk_i) disable iff (rst_i)  // R12
    (wr_lane0 && wb_adr_i == OFS_ADDRESS_DATA_SELECT_B) |=> address_data_select_b == $past(wb_dat_i[7:0]))
    else $error("Third select write not stored.");
  AST_R11_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)  // R11
    !hold_select |-> !wait_request_o)
    else $error("Wait request raised while hold select is clear.");
  AST_R11_LOW: assert property (@(posedge clk_i) disable iff (rst_i)  // R11
    (hold_select && !$past(hold_pin_i, 2)) |-> !wait_request_o)
    else $error("Wait request raised with the hold pin low.");
  AST_R11_READ: assert property (@(posedge clk_i) disable iff (rst_i)  // R11
    (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == OFS_HOLD_SELECT) |-> wb_dat_o[6:0] == 7'h00)
    else $error("Hold select register returned unused bits.");

endmodule

/* File: verif/ext_bus_partner.sv */
`timescale 1ns/1ps
// ****************************************************************
// Slow peripheral driving the hold pin
// ****************************************************************
module ext_bus_partner
(
  input  wire logic clk_i,
  input  wire logic want_i,
  output logic      hold_o
);
  // The request leaves from the peripheral's own edge, a cycle after the ask.
  initial hold_o = 1'b0;
  always @(posedge clk_i)
  begin
    hold_o <= want_i;
  end
endmodule

/* File: verif/expansion_bus_pin_mux_tb_top.sv */
`timescale 1ns/1ps
module expansion_bus_pin_mux_tb_top;
  import pin_route_pkg::*;
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic        clk_i     = 1'b0;
  logic        rst_i     = 1'b1;
  logic        cyc       = 1'b0;
  logic        stb       = 1'b0;
  logic        we        = 1'b0;
  logic [4:0]  adr       = 5'h00;
  logic [3:0]  sel       = 4'h0;
  logic [31:0] wdat      = 32'h0;
  logic [29:0] addr_src  = 30'h2a5c3e91;
  logic [15:0] data_src  = 16'hb7d4;
  logic [23:0] gpio      = 24'h96e1c3;
  logic        hold_want = 1'b0;
  logic [31:0] rdat;
  logic        ack;
  logic        err;
  logic [23:0] pins;
  logic        hold;
  logic        wreq;
  logic        pdn;
  logic        wide;
  logic [31:0] q;
  logic        e;
  logic [23:0] pat;
  int          err_total = 0;
  int          compares  = 0;
  int          cycles    = 0;
  logic [4:0]  offs [5]  = '{OFS_UPPER_ADDR_DATA_SELECT, OFS_ADDRESS_DATA_SELECT_A, OFS_ADDRESS_DATA_SELECT_B,
                             OFS_WIDTH_AND_POWER_CTRL, OFS_HOLD_SELECT};

  expansion_bus_pin_mux uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .bus_address_line_i(addr_src), .bus_data_line_i(data_src), .gpio_out_i(gpio), .pin_out_o(pins),
    .hold_pin_i(hold), .wait_request_o(wreq), .local_power_down_o(pdn), .bus_wide_o(wide));
  ext_bus_partner peer (.clk_i(clk_i), .want_i(hold_want), .hold_o(hold));

  initial forever #5 clk_i = ~clk_i;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task end_sim;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The request is held until ack or err is seen, so slave latency never matters.
  task wb(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, wdat} <= {1'b1, 1'b1, w, a, s, 24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
    q = rdat;
    e = err;
    {cyc, stb, we} <= 3'b000;
  endtask

  function automatic logic [23:0] exp_pins(input logic [23:0] s, input logic w);
    logic [23:0] src;
    src = w ? {addr_src[21:14], addr_src[13:6], data_src[15:8]} : {addr_src[29:22], addr_src[21:14], addr_src[13:6]};
    return (s & src) | (~s & gpio);
  endfunction

  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      err_total++;
      end_sim();
    end
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk(pins, gpio);
    foreach (offs[i])
    begin
      wb(1'b0, offs[i], 8'h00, 4'hf);
      chk(q, 32'h0);
    end
    wb(1'b1, 5'h08, 8'hff, 4'h1);
    @(negedge clk_i);
    chk({e, pins}, {1'b1, gpio});
    wb(1'b1, OFS_WIDTH_AND_POWER_CTRL, 8'hff, 4'h1);
    wb(1'b0, OFS_WIDTH_AND_POWER_CTRL, 8'h00, 4'hf);
    chk(q, 32'h07);
    chk({pdn, wide}, 2'b10);
    wb(1'b1, OFS_WIDTH_AND_POWER_CTRL, 8'h02, 4'h1);
    wb(1'b1, OFS_WIDTH_AND_POWER_CTRL, 8'h00, 4'he);
    @(negedge clk_i);
    chk({pdn, wide}, 2'b01);
    for (int w = 0; w < 2; w++)
    begin
      wb(1'b1, OFS_WIDTH_AND_POWER_CTRL, {6'h0, w[0], 1'b0}, 4'h1);
      for (int p = 0; p < 2; p++)
      begin
        pat = p[0] ? 24'hf03ca5 : 24'h0fc35a;
        wb(1'b1, OFS_UPPER_ADDR_DATA_SELECT, pat[7:0], 4'h1);
        wb(1'b1, OFS_ADDRESS_DATA_SELECT_A, pat[15:8], 4'h1);
        wb(1'b1, OFS_ADDRESS_DATA_SELECT_B, pat[23:16], 4'h1);
        @(negedge clk_i);
        chk(pins, exp_pins(pat, w[0]));
        wb(1'b0, OFS_ADDRESS_DATA_SELECT_A, 8'h00, 4'hf);
        chk(q, {24'h0, pat[15:8]});
        gpio     <= ~gpio;
        addr_src <= ~addr_src;
        data_src <= ~data_src;
        @(negedge clk_i);
        chk(pins, exp_pins(pat, w[0]));
      end
    end
    wb(1'b1, OFS_HOLD_SELECT, 8'h80, 4'h1);
    hold_want <= 1'b1;
    repeat (6) if (wreq !== 1'b1) @(negedge clk_i);
    chk(wreq, 1'b1);
    wb(1'b1, OFS_HOLD_SELECT, 8'h00, 4'h1);
    chk(wreq, 1'b0);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({wreq, pdn, wide, pins}, {3'b000, gpio});
    wb(1'b0, OFS_UPPER_ADDR_DATA_SELECT, 8'h00, 4'hf);
    chk({q[7:0], pins}, {8'h00, gpio});
    end_sim();
  end
endmodule
